// >>> design/rtc_cal.sv
// Next-second calculator: one-second advance of the time and calendar,
// in BCD or binary, 12 or 24 hour form, with daylight saving jumps.
// Purely combinational; the caller decides when to load the result.
`timescale 1ns/1ps
module rtc_cal (
  input wire logic [7:0] sec,
  input wire logic [7:0] min,
  input wire logic [7:0] hr,
  input wire logic [7:0] dow,
  input wire logic [7:0] dom,
  input wire logic [7:0] mon,
  input wire logic [7:0] yr,
  input wire logic binary_format,
  input wire logic hour24,
  input wire logic daylight_saving_en,
  input wire logic fall_done,
  output logic [7:0] n_sec,
  output logic [7:0] n_min,
  output logic [7:0] n_hr,
  output logic [7:0] n_dow,
  output logic [7:0] n_dom,
  output logic [7:0] n_mon,
  output logic [7:0] n_yr,
  output logic fall_hit
);
  function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bin);
    return bin ? v : 8'(8'(v[7:4]) * 8'd10 + {4'h0, v[3:0]});
  endfunction

  function automatic logic [7:0] from_bin(input logic [7:0] v, input logic bin);
    return bin ? v : {4'(v / 8'd10), 4'(v % 8'd10)};
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
    logic [7:0] d;
    d = 8'd31;
    if (m == rtc_pkg::MON_FEB) begin
      d = (y[1:0] == 2'b00) ? 8'd29 : 8'd28;
    end else if (m == 8'd4 || m == 8'd6 || m == 8'd9 || m == 8'd11) begin
      d = 8'd30;
    end
    return d;
  endfunction

  logic [7:0] s, m, h, h0, wd, d, mo, y, hraw, h12, hb;
  logic day_carry, at_159, spring, fall;

  always_comb begin
    h12 = 8'd0;
    hb = 8'd0;
    s = to_bin(sec, binary_format);
    m = to_bin(min, binary_format);
    hraw = to_bin({1'b0, hr[6:0]}, binary_format);
    if (hour24) begin
      h0 = hraw;
    end else begin
      h0 = (hraw == rtc_pkg::HR_HALF) ? 8'd0 : hraw;
      if (hr[7]) begin
        h0 = h0 + rtc_pkg::HR_HALF;
      end
    end
    wd = to_bin(dow, binary_format);
    d = to_bin(dom, binary_format);
    mo = to_bin(mon, binary_format);
    y = to_bin(yr, binary_format);
    at_159 = (h0 == rtc_pkg::DST_HOUR) && (m == rtc_pkg::SEC_WRAP - 8'd1) && (s == rtc_pkg::SEC_WRAP - 8'd1);
    spring = daylight_saving_en && at_159 && mo == rtc_pkg::MON_APR && wd == rtc_pkg::SUNDAY &&
             d <= rtc_pkg::FIRST_WEEK_END;
    fall = daylight_saving_en && at_159 && mo == rtc_pkg::MON_OCT && wd == rtc_pkg::SUNDAY &&
           d >= rtc_pkg::LAST_WEEK_START && !fall_done;
    fall_hit = fall;
    day_carry = 1'b0;
    h = h0;
    s = s + 8'd1;
    if (s == rtc_pkg::SEC_WRAP) begin
      s = 8'd0;
      m = m + 8'd1;
      if (m == rtc_pkg::SEC_WRAP) begin
        m = 8'd0;
        h = h + 8'd1;
        if (h == rtc_pkg::HR_WRAP) begin
          h = 8'd0;
          day_carry = 1'b1;
        end
      end
    end
    if (spring) begin
      h = rtc_pkg::DST_SPRING_HOUR;
    end else if (fall) begin
      h = rtc_pkg::DST_HOUR;
    end
    if (day_carry) begin
      wd = (wd >= rtc_pkg::DOW_LAST) ? 8'd1 : wd + 8'd1;
      if (d >= month_days(mo, y)) begin
        d = 8'd1;
        if (mo >= rtc_pkg::MON_LAST) begin
          mo = 8'd1;
          y = (y >= rtc_pkg::YEAR_LAST) ? 8'd0 : y + 8'd1;
        end else begin
          mo = mo + 8'd1;
        end
      end else begin
        d = d + 8'd1;
      end
    end
    n_sec = from_bin(s, binary_format);
    n_min = from_bin(m, binary_format);
    if (hour24) begin
      n_hr = from_bin(h, binary_format);
    end else begin
      h12 = (h >= rtc_pkg::HR_HALF) ? h - rtc_pkg::HR_HALF : h;
      if (h12 == 8'd0) begin
        h12 = rtc_pkg::HR_HALF;
      end
      hb = from_bin(h12, binary_format);
      n_hr = {h >= rtc_pkg::HR_HALF, hb[6:0]};
    end
    n_dow = from_bin(wd, binary_format);
    n_dom = from_bin(d, binary_format);
    n_mon = from_bin(mo, binary_format);
    n_yr = from_bin(y, binary_format);
  end
endmodule

// >>> design/rtc_core.sv
// Real-time clock core behind the index/data port pair: time and calendar
// with user copy, control and flag registers, alarm, periodic events,
// banked RAM with range lock, and power transition bus lockout.
// Assumes host strobes are one-cycle pulses on clk_sys; crystal and power
// pins are asynchronous and are synchronised here.
// Functional notes
// - Freeze bit snapshots; release reloads internal time
// - Next update 1000 ms after update-done
// - Update-pending high 244 us before update
// - Update-pending reads 0 while frozen
// - Periodic event precedes update by P/2+244us
// - Alarm flag 30.5 us after update
// - Compare seconds, minutes, hours after update
// - Alarm byte with top bits 11 matches
// - Flag read or clock reset clears flags
// - Bank 0 RAM 0E-7F, bank 1 00-7F
// - Locked 38-3F ignores writes, reads FF
// - Lock bus on battery, 62 ms after
// - Skip lockout delay if not normal or invalid
// - Low battery plus strap: open, clear 00-0D
// - Oscillator stopped when invalid or divider 00x
// - Other events keep request; repeats lost
// - Control registers at 0A-0D, reachable only with bank 0 selected
// - Rate field selects periodic interval
// - Divider field: off, normal, test, held
// - Daylight saving spring and fall jumps
// - Hour format bit selects 24/12
// - Binary or BCD; mode bit 3 reads 0
// - Flag register layout, cleared by read
// - Interrupt enables cleared by reset
`timescale 1ns/1ps
module rtc_core #(
  parameter int LOCKOUT_CYCLES = rtc_pkg::LOCKOUT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic osc_32k,
  input wire logic sys_power_good,
  input wire logic battery_low,
  input wire logic master_clear_strap,
  input wire logic clock_reset_n,
  input wire logic io_sel_data,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic ram_bank_select,
  input wire logic ram_lock_set,
  output logic interrupt_request_n,
  output logic bus_lockout
);
  typedef struct packed {
    logic [2:0][rtc_pkg::NPINS-1:0] sy;
    logic [rtc_pkg::NPINS-1:0] pin_f;
    logic osc_prev;
    logic pwr_prev;
    logic [6:0] index;
    logic [rtc_pkg::NUM_USER-1:0][7:0] user;
    logic [rtc_pkg::NUM_LIVE-1:0][7:0] live;
    logic [3:0] periodic_rate_sel;
    logic [2:0] divider_ctrl;
    logic [7:0] mode;
    logic periodic_flag;
    logic alarm_flag;
    logic update_done_flag;
    logic valid_ram_time;
    logic ram_lock;
    logic [3:0] alarm_wait;
    logic fall_done;
    logic [rtc_pkg::DIV_W-1:0] div;
    rtc_pkg::rtc_lock_t lk;
    logic [31:0] lk_cnt;
    logic [7:0] rdata;
  } rtc_state_t;


  rtc_state_t cur, nxt;
  logic [7:0] ram_q;
  logic ram_we;
  logic [7:0] n_sec, n_min, n_hr, n_dow, n_dom, n_mon, n_yr;
  logic fall_hit;

  // Live slot i sits at this user index (alarms interleave the first three)
  function automatic int live_to_user(input int i);
    return (i < 3) ? 2 * i : i + 3;
  endfunction

  function automatic logic alarm_ok(input logic [7:0] alarm, input logic [7:0] now);
    return (alarm[7:6] == rtc_pkg::ALARM_ANY) || (alarm == now);
  endfunction

  // Periodic interval as a power of two of crystal ticks, 0 for none
  function automatic logic [3:0] rate_log2(input logic [3:0] r);
    logic [3:0] e;
    unique case (r)
      4'h0: e = 4'h0;
      4'h1: e = 4'h7;
      4'h2: e = 4'h8;
      default: e = r - 4'h1;
    endcase
    return e;
  endfunction

  function automatic logic in_lock_range(input logic [6:0] idx);
    return idx >= rtc_pkg::IDX_LOCK_LO && idx <= rtc_pkg::IDX_LOCK_HI;
  endfunction

  rtc_cal u_cal (
    .sec(cur.live[0]),
    .min(cur.live[1]),
    .hr(cur.live[2]),
    .dow(cur.live[3]),
    .dom(cur.live[4]),
    .mon(cur.live[5]),
    .yr(cur.live[6]),
    .binary_format(cur.mode[rtc_pkg::B_DM]),
    .hour24(cur.mode[rtc_pkg::B_H24]),
    .daylight_saving_en(cur.mode[rtc_pkg::B_DSE]),
    .fall_done(cur.fall_done),
    .n_sec(n_sec),
    .n_min(n_min),
    .n_hr(n_hr),
    .n_dow(n_dow),
    .n_dom(n_dom),
    .n_mon(n_mon),
    .n_yr(n_yr),
    .fall_hit(fall_hit)
  );

  logic osc_tick, pwr, pwr_rise, run, held, frozen, update, per_evt, irq;
  logic clr_flags, crst, rd_data, wr_data, ram_region, open;
  logic [rtc_pkg::DIV_W-1:0] div_inc, per_pos, per_mask;
  logic [3:0] e;
  logic [7:0] ctrl_a, flags, rd_val;
  logic [rtc_pkg::NUM_LIVE-1:0][7:0] adv;

  always_comb begin
    nxt = cur;
    // Three-stage sync; a change counts once stages two and three agree
    nxt.sy = {cur.sy[1:0], {clock_reset_n, master_clear_strap, battery_low, sys_power_good, osc_32k}};
    for (int i = 0; i < rtc_pkg::NPINS; i++) begin
      if (cur.sy[1][i] == cur.sy[2][i]) begin
        nxt.pin_f[i] = cur.sy[1][i];
      end
    end
    nxt.osc_prev = cur.pin_f[rtc_pkg::PIN_OSC];
    nxt.pwr_prev = cur.pin_f[rtc_pkg::PIN_PWR];
    osc_tick = cur.pin_f[rtc_pkg::PIN_OSC] && !cur.osc_prev;
    pwr = cur.pin_f[rtc_pkg::PIN_PWR];
    pwr_rise = pwr && !cur.pwr_prev;
    crst = !cur.pin_f[rtc_pkg::PIN_CRST];
    frozen = cur.mode[rtc_pkg::B_SET];
    open = cur.lk == rtc_pkg::LK_OPEN;

    run = cur.valid_ram_time && (cur.divider_ctrl[2] || cur.divider_ctrl[1]);
    held = cur.divider_ctrl[2] && cur.divider_ctrl[1];
    div_inc = cur.div + 1'b1;
    update = run && !held && osc_tick && cur.div == rtc_pkg::DIV_LAST && !frozen;
    if (held) begin
      // Restart half way so the first update lands 500 ms after release
      nxt.div = rtc_pkg::DIV_RESTART;
    end else if (run && osc_tick) begin
      nxt.div = div_inc;
    end

    // Periodic event placed P/2 + lead before the wrap
    e = rate_log2(cur.periodic_rate_sel);
    per_mask = rtc_pkg::DIV_W'((32'd1 << e) - 32'd1);
    per_pos = div_inc + rtc_pkg::DIV_W'(32'd1 << (e - 4'h1)) + rtc_pkg::DIV_W'(rtc_pkg::UIP_TICKS);
    per_evt = run && !held && osc_tick && e != 4'h0 && (per_pos & per_mask) == '0;

    // Update-pending window; forced low when frozen
    ctrl_a = {run && !held && !frozen && cur.div >= rtc_pkg::DIV_UIP_START,
              cur.divider_ctrl, cur.periodic_rate_sel};

    irq = (cur.mode[rtc_pkg::B_PIE] && cur.periodic_flag) || (cur.mode[rtc_pkg::B_AIE] && cur.alarm_flag) ||
          (cur.mode[rtc_pkg::B_UIE] && cur.update_done_flag);
    flags = '0;
    flags[rtc_pkg::C_REQUEST_PENDING_FLAG] = irq;
    flags[rtc_pkg::C_PF] = cur.periodic_flag;
    flags[rtc_pkg::C_AF] = cur.alarm_flag;
    flags[rtc_pkg::C_UF] = cur.update_done_flag;

    rd_data = io_rd && io_sel_data && open;
    wr_data = io_wr && io_sel_data && open;
    ram_region = ram_bank_select || cur.index >= rtc_pkg::IDX_RAM0_LO;
    ram_we = wr_data && ram_region && !(cur.ram_lock && in_lock_range(cur.index));

    clr_flags = rd_data && !ram_region && cur.index == rtc_pkg::IDX_FLAGS;

    // Advance and mirror into the user copy
    adv = {n_yr, n_mon, n_dom, n_dow, n_hr, n_min, n_sec};
    if (update) begin
      nxt.live = adv;
      for (int i = 0; i < rtc_pkg::NUM_LIVE; i++) begin
        nxt.user[live_to_user(i)] = adv[i];
      end
      nxt.fall_done = fall_hit || (cur.fall_done && n_hr == cur.live[2]);
    end

    // Alarm compare on the new time; flag one tick later
    if (update && alarm_ok(cur.user[rtc_pkg::IDX_SEC_ALM], n_sec) && alarm_ok(cur.user[rtc_pkg::IDX_MIN_ALM], n_min) &&
        alarm_ok(cur.user[rtc_pkg::IDX_HR_ALM], n_hr)) begin
      nxt.alarm_wait = rtc_pkg::ALARM_TICKS_W;
    end else if (cur.alarm_wait != 4'h0 && osc_tick) begin
      nxt.alarm_wait = cur.alarm_wait - 4'h1;
    end

    // New event wins over the read clear; repeats merge
    nxt.periodic_flag = per_evt || (cur.periodic_flag && !clr_flags);
    nxt.update_done_flag = update || (cur.update_done_flag && !clr_flags);
    nxt.alarm_flag = (cur.alarm_wait == 4'h1 && osc_tick) || (cur.alarm_flag && !clr_flags);

    // Lock is sticky until hardware reset
    nxt.ram_lock = cur.ram_lock || ram_lock_set;

    // Host writes
    if (io_wr && !io_sel_data && open) begin
      nxt.index = io_wdata[6:0];
    end
    if (wr_data && !ram_region) begin
      if (cur.index <= rtc_pkg::IDX_YEAR) begin
        nxt.user[cur.index] = io_wdata;
        for (int i = 0; i < rtc_pkg::NUM_LIVE; i++) begin
          if (!frozen && cur.index == 7'(live_to_user(i))) begin
            nxt.live[i] = io_wdata;
          end
        end
      end else if (cur.index == rtc_pkg::IDX_CTRL_A) begin
        nxt.divider_ctrl = io_wdata[rtc_pkg::A_DV_LO +: 3];
        nxt.periodic_rate_sel = io_wdata[3:0];
      end else if (cur.index == rtc_pkg::IDX_CTRL_B) begin
        nxt.mode = io_wdata & rtc_pkg::MODE_WR_MASK;
        // Snapshot on set, reload on release
        if (io_wdata[rtc_pkg::B_SET] && !frozen) begin
          for (int i = 0; i < rtc_pkg::NUM_LIVE; i++) begin
            nxt.user[live_to_user(i)] = cur.live[i];
          end
        end else if (!io_wdata[rtc_pkg::B_SET] && frozen) begin
          for (int i = 0; i < rtc_pkg::NUM_LIVE; i++) begin
            nxt.live[i] = cur.user[live_to_user(i)];
          end
        end
      end
    end

    // Host reads; control block at 0A-0D
    rd_val = ram_q;
    if (ram_region && cur.ram_lock && in_lock_range(cur.index)) begin
      rd_val = rtc_pkg::LOCKED_FILL;
    end else if (!ram_region) begin
      if (cur.index <= rtc_pkg::IDX_YEAR) begin
        rd_val = cur.user[cur.index];
      end else if (cur.index == rtc_pkg::IDX_CTRL_A) begin
        rd_val = ctrl_a;
      end else if (cur.index == rtc_pkg::IDX_CTRL_B) begin
        rd_val = cur.mode;
      end else if (cur.index == rtc_pkg::IDX_FLAGS) begin
        rd_val = flags;
      end else begin
        rd_val = {cur.valid_ram_time, 7'h00};
        nxt.valid_ram_time = cur.valid_ram_time || rd_data;
      end
    end
    if (io_rd && open) begin
      nxt.rdata = io_sel_data ? rd_val : {1'b0, cur.index};
    end else if (io_rd) begin
      nxt.rdata = rtc_pkg::LOCKED_FILL;
    end

    // Clock reset clears flags; and enables
    if (crst) begin
      nxt.periodic_flag = 1'b0;
      nxt.alarm_flag = 1'b0;
      nxt.update_done_flag = 1'b0;
      nxt.alarm_wait = 4'h0;
      nxt.mode[rtc_pkg::B_PIE] = 1'b0;
      nxt.mode[rtc_pkg::B_AIE] = 1'b0;
      nxt.mode[rtc_pkg::B_UIE] = 1'b0;
    end

    // Power transition lockout
    unique case (cur.lk)
      rtc_pkg::LK_LOCKED: begin
        nxt.lk_cnt = '0;
        if (pwr_rise) begin
          // Low battery with strap opens and clears
          if (cur.pin_f[rtc_pkg::PIN_BATT] && cur.pin_f[rtc_pkg::PIN_MR]) begin
            nxt.lk = rtc_pkg::LK_OPEN;
            nxt.user = '0;
            nxt.live = '0;
            nxt.mode = rtc_pkg::CLEAR_BYTE;
            nxt.divider_ctrl = '0;
            nxt.periodic_rate_sel = '0;
            nxt.periodic_flag = 1'b0;
            nxt.alarm_flag = 1'b0;
            nxt.update_done_flag = 1'b0;
            nxt.valid_ram_time = 1'b0;
          // No delay outside normal mode or when invalid
          end else if (cur.divider_ctrl != rtc_pkg::DV_NORMAL || !cur.valid_ram_time) begin
            nxt.lk = rtc_pkg::LK_OPEN;
          end else begin
            nxt.lk = rtc_pkg::LK_WAIT;
          end
        end
      end
      rtc_pkg::LK_WAIT: begin
        // Hold the minimum lockout after power returns
        nxt.lk_cnt = cur.lk_cnt + 32'd1;
        if (!pwr) begin
          nxt.lk = rtc_pkg::LK_LOCKED;
        end else if (cur.lk_cnt >= 32'(LOCKOUT_CYCLES - 1)) begin
          nxt.lk = rtc_pkg::LK_OPEN;
        end
      end
      rtc_pkg::LK_OPEN: begin
        nxt.lk_cnt = '0;
        if (!pwr) begin
          nxt.lk = rtc_pkg::LK_LOCKED;
        end
      end
      default: nxt.lk = rtc_pkg::LK_LOCKED;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '{lk: rtc_pkg::LK_LOCKED, default: '0};
    end else begin
      cur <= nxt;
    end
  end

  rtc_ram #(
    .AW(8),
    .DW(8)
  ) u_ram (
    .clk_sys(clk_sys),
    .we(ram_we),
    .waddr({ram_bank_select, cur.index}),
    .wdata(io_wdata),
    .raddr({ram_bank_select, cur.index}),
    .rdata(ram_q)
  );

  assign io_rdata = cur.rdata;
  // Request line low while any enabled flag stands
  assign interrupt_request_n = !irq;
  assign bus_lockout = !open;
endmodule

// >>> design/rtc_pkg.sv
// Shared constants for the real-time clock core: index map, bit fields,
// divider figures, lockout timing and the state enumeration.
// Assumes a 250 MHz system clock and a 32.768 kHz crystal input.
package rtc_pkg;

  // Index map
  localparam logic [6:0] IDX_SEC = 7'h00;
  localparam logic [6:0] IDX_SEC_ALM = 7'h01;
  localparam logic [6:0] IDX_MIN_ALM = 7'h03;
  localparam logic [6:0] IDX_HR_ALM = 7'h05;
  localparam logic [6:0] IDX_YEAR = 7'h09;
  localparam logic [6:0] IDX_CTRL_A = 7'h0a;
  localparam logic [6:0] IDX_CTRL_B = 7'h0b;
  localparam logic [6:0] IDX_FLAGS = 7'h0c;
  localparam logic [6:0] IDX_VALID = 7'h0d;
  localparam logic [6:0] IDX_RAM0_LO = 7'h0e;
  localparam logic [6:0] IDX_LOCK_LO = 7'h38;
  localparam logic [6:0] IDX_LOCK_HI = 7'h3f;
  localparam int NUM_USER = 10;
  localparam int NUM_LIVE = 7;

  // Divider / rate field of the periodic_divider_control register
  localparam int A_UIP = 7;
  localparam int A_DV_LO = 4;
  localparam logic [2:0] DV_NORMAL = 3'b010;

  // Fields of rtc_mode_control
  localparam int B_SET = 7;
  localparam int B_PIE = 6;
  localparam int B_AIE = 5;
  localparam int B_UIE = 4;
  localparam int B_DM = 2;
  localparam int B_H24 = 1;
  localparam int B_DSE = 0;
  localparam logic [7:0] MODE_WR_MASK = 8'hf7;

  // Flag and validity registers
  localparam int C_REQUEST_PENDING_FLAG = 7;
  localparam int C_PF = 6;
  localparam int C_AF = 5;
  localparam int C_UF = 4;
  localparam int D_VRT = 7;

  localparam logic [7:0] LOCKED_FILL = 8'hff;
  localparam logic [7:0] CLEAR_BYTE = 8'h00;
  localparam logic [1:0] ALARM_ANY = 2'b11;

  // Time base
  localparam int OSC_HZ = 32768;
  localparam int DIV_W = 15;
  localparam logic [DIV_W-1:0] DIV_LAST = 15'h7fff;
  localparam logic [DIV_W-1:0] DIV_RESTART = 15'h4000;
  localparam int UIP_LEAD_US = 244;
  localparam int UIP_TICKS = (UIP_LEAD_US * OSC_HZ + 999999) / 1000000;
  localparam logic [DIV_W-1:0] DIV_UIP_START = DIV_LAST - DIV_W'(UIP_TICKS - 1);
  localparam int ALARM_DELAY_US_X10 = 305;
  localparam int ALARM_TICKS = (ALARM_DELAY_US_X10 * OSC_HZ + 9999999) / 10000000;
  localparam logic [3:0] ALARM_TICKS_W = 4'(ALARM_TICKS < 1 ? 1 : ALARM_TICKS);

  // Power transition lockout
  localparam int CLK_MHZ = 250;
  localparam int LOCKOUT_MIN_MS = 62;
  localparam int LOCKOUT_CYCLES = LOCKOUT_MIN_MS * CLK_MHZ * 1000;

  // Calendar limits
  localparam logic [7:0] SEC_WRAP = 8'd60;
  localparam logic [7:0] HR_WRAP = 8'd24;
  localparam logic [7:0] HR_HALF = 8'd12;
  localparam logic [7:0] DOW_LAST = 8'd7;
  localparam logic [7:0] MON_LAST = 8'd12;
  localparam logic [7:0] YEAR_LAST = 8'd99;
  localparam logic [7:0] SUNDAY = 8'd1;
  localparam logic [7:0] MON_FEB = 8'd2;
  localparam logic [7:0] MON_APR = 8'd4;
  localparam logic [7:0] MON_OCT = 8'd10;
  localparam logic [7:0] FIRST_WEEK_END = 8'd7;
  localparam logic [7:0] LAST_WEEK_START = 8'd25;
  localparam logic [7:0] DST_HOUR = 8'd1;
  localparam logic [7:0] DST_SPRING_HOUR = 8'd3;

  // Synchronised pins
  localparam int PIN_OSC = 0;
  localparam int PIN_PWR = 1;
  localparam int PIN_BATT = 2;
  localparam int PIN_MR = 3;
  localparam int PIN_CRST = 4;
  localparam int NPINS = 5;

  typedef enum logic [2:0] {
    LK_LOCKED = 3'b001,
    LK_WAIT = 3'b010,
    LK_OPEN = 3'b100
  } rtc_lock_t;

endpackage

// >>> design/rtc_ram.sv
// General purpose battery-backed byte store, both banks in one array.
// Read data is registered; one write port, one read port, same clock.
`timescale 1ns/1ps
module rtc_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // No reset: contents live across system resets
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// >>> verif/rtc_core_props.sv
// Port checks of the clock core; bound to rtc_core.
// Tracks the index and the RAM lock from the ports alone.
`timescale 1ns/1ps
module rtc_core_props #(
  parameter int LOCKOUT_CYCLES = 50
) (
  input wire logic clk_sys, input wire logic rst_n, input wire logic osc_32k,
  input wire logic sys_power_good, input wire logic battery_low, input wire logic master_clear_strap,
  input wire logic clock_reset_n, input wire logic io_sel_data, input wire logic io_wr,
  input wire logic io_rd, input wire logic [7:0] io_wdata, input wire logic [7:0] io_rdata,
  input wire logic ram_bank_select, input wire logic ram_lock_set,
  input wire logic interrupt_request_n, input wire logic bus_lockout
);
  logic [6:0] idx;
  logic lock_seen;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 7'h00;
      lock_seen <= 1'b0;
    end else begin
      if (io_wr && !io_sel_data && !bus_lockout) idx <= io_wdata[6:0];
      if (ram_lock_set) lock_seen <= 1'b1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_data_rd(logic [6:0] i);
    io_rd && io_sel_data && !bus_lockout && !ram_bank_select && idx == i;
  endsequence
  sequence s_lock_rd;
    io_rd && io_sel_data && !bus_lockout && lock_seen && idx >= 7'h38 && idx <= 7'h3f;
  endsequence
  AST_LOCKED_READ: assert property (io_rd && bus_lockout |=> io_rdata == 8'hff)
    else $error("read in lockout not ff");
  AST_POWER_LOCK: assert property (!sys_power_good [*8] |-> bus_lockout)
    else $error("bus open without power");
  AST_HOLD: assert property (!io_rd |=> $stable(io_rdata))
    else $error("read data moved without read");
  AST_INDEX: assert property (io_rd && !io_sel_data && !bus_lockout |=> io_rdata == {1'b0, $past(idx)})
    else $error("index read wrong");
  AST_FLAGS: assert property (s_data_rd(7'h0c) |=> io_rdata[7] == !$past(interrupt_request_n) && io_rdata[3:0] == 4'h0)
    else $error("flag byte wrong");
  AST_MODE_B3: assert property (s_data_rd(7'h0b) |=> !io_rdata[3])
    else $error("mode bit 3 set");
  AST_VALID_ZERO: assert property (s_data_rd(7'h0d) |=> io_rdata[6:0] == 7'h00)
    else $error("valid byte low bits set");
  AST_RAM_LOCK: assert property (s_lock_rd |=> io_rdata == 8'hff)
    else $error("locked ram readable");
  AST_CLK_RESET: assert property (!clock_reset_n [*8] |-> interrupt_request_n)
    else $error("request during clock reset");
endmodule

// >>> verif/rtc_host.sv
// Host model on the index/data port pair of the clock core.
// Assumes the core takes strobes at posedge clk_sys.
`timescale 1ns/1ps
module rtc_host (
  input wire logic clk_sys,
  input wire logic [7:0] io_rdata,
  output logic io_sel_data = 1'b0,
  output logic io_wr = 1'b0,
  output logic io_rd = 1'b0,
  output logic [7:0] io_wdata = 8'h00
);
  task automatic put(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    io_sel_data <= 1'b0;
    io_wr <= 1'b1;
    io_wdata <= idx;
    @(posedge clk_sys);
    io_sel_data <= 1'b1;
    io_wdata <= d;
    @(posedge clk_sys);
    io_wr <= 1'b0;
    io_wdata <= ~d;
  endtask
  task automatic get(input logic [7:0] idx, output logic [7:0] d);
    @(posedge clk_sys);
    io_sel_data <= 1'b0;
    io_wr <= 1'b1;
    io_wdata <= idx;
    @(posedge clk_sys);
    io_wr <= 1'b0;
    io_wdata <= ~idx;
    @(posedge clk_sys);
    io_sel_data <= 1'b1;
    io_rd <= 1'b1;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    @(posedge clk_sys);
    d = io_rdata;
  endtask
  task automatic peek(output logic [7:0] d);
    @(posedge clk_sys);
    io_sel_data <= 1'b0;
    io_rd <= 1'b1;
    @(posedge clk_sys);
    io_rd <= 1'b0;
    @(posedge clk_sys);
    d = io_rdata;
  endtask
endmodule

// >>> verif/testbench.sv
// Self-checking bench of the clock core: RAM banks and lock, control
// registers, periodic flag, clock reset and power lockout.
// Assumes rtc_host on the port pair; lockout shortened to LK cycles.
`timescale 1ns/1ps
module testbench;
  localparam int LK = 50;
  logic clk_sys = 1'b0, rst_n = 1'b0, osc_32k = 1'b0, sys_power_good = 1'b1;
  logic battery_low = 1'b0, master_clear_strap = 1'b0, clock_reset_n = 1'b1;
  logic ram_bank_select = 1'b0, ram_lock_set = 1'b0, locked = 1'b0;
  logic io_sel_data, io_wr, io_rd, interrupt_request_n, bus_lockout;
  logic [7:0] io_wdata, io_rdata, d, a;
  logic [31:0] seed = 32'hdd5027a1;
  logic [7:0] mem [2][128];
  int n_errors = 0, compares = 0, cycles = 0;
  rtc_core #(.LOCKOUT_CYCLES(LK)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .osc_32k(osc_32k),
    .sys_power_good(sys_power_good), .battery_low(battery_low), .master_clear_strap(master_clear_strap),
    .clock_reset_n(clock_reset_n), .io_sel_data(io_sel_data), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .ram_bank_select(ram_bank_select),
    .ram_lock_set(ram_lock_set), .interrupt_request_n(interrupt_request_n), .bus_lockout(bus_lockout));
  rtc_host h (.clk_sys(clk_sys), .io_rdata(io_rdata), .io_sel_data(io_sel_data), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata));
  always #2 clk_sys = ~clk_sys;
  // Crystal sped up so periodic events fit the run
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles % 4 == 3) osc_32k <= ~osc_32k;
    if (cycles > 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_low(ref logic s);
    repeat (300) if (s) @(negedge clk_sys);
  endtask
  task automatic bank_walk(input int b, input bit wr);
    ram_bank_select <= b[0];
    for (int i = 0; i < 6; i++) begin
      a = (b == 0) ? 8'h0e + 8'(i * 22) : 8'(i * 25);
      if (wr) begin
        mem[b][a] = rnd();
        h.put(a, mem[b][a]);
      end else begin
        h.get(a, d);
        chk(d, (locked && a >= 8'h38 && a <= 8'h3f) ? 8'hff : mem[b][a]);
      end
    end
  endtask
  task automatic power_cycle(input logic low);
    sys_power_good <= 1'b0;
    battery_low <= low;
    master_clear_strap <= low;
    repeat (10) @(posedge clk_sys);
    h.get(8'h0a, d);
    chk(d, 8'hff);
    sys_power_good <= 1'b1;
    repeat (12) @(posedge clk_sys);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_low(bus_lockout);
    h.get(8'h0d, d);
    chk(d, 8'h00);
    h.get(8'h0d, d);
    chk(d, 8'h80);
    for (int b = 0; b < 2; b++) begin
      bank_walk(b, 1);
      bank_walk(b, 0);
    end
    ram_lock_set <= 1'b1;
    @(posedge clk_sys);
    ram_lock_set <= 1'b0;
    locked = 1'b1;
    h.put(8'h3a, 8'h5a);
    bank_walk(0, 0);
    h.put(8'h0a, 8'ha3);
    h.put(8'h0b, 8'h8f);
    h.get(8'h0b, d);
    chk(d, 8'h87);
    h.get(8'h0a, d);
    chk(d, 8'h23);
    h.put(8'h0b, 8'h42);
    wait_low(interrupt_request_n);
    chk({7'h0, interrupt_request_n}, 8'h00);
    h.get(8'h0c, d);
    chk(d, 8'hc0);
    chk({7'h0, interrupt_request_n}, 8'h01);
    h.put(8'h0b, 8'h72);
    clock_reset_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    clock_reset_n <= 1'b1;
    h.get(8'h0b, d);
    chk(d, 8'h02);
    h.peek(d);
    chk(d, 8'h0b);
    power_cycle(1'b0);
    chk({7'h0, bus_lockout}, 8'h01);
    wait_low(bus_lockout);
    chk({7'h0, bus_lockout}, 8'h00);
    power_cycle(1'b1);
    chk({7'h0, bus_lockout}, 8'h00);
    h.get(8'h0a, d);
    chk(d, 8'h00);
    h.get(8'h0d, d);
    chk(d, 8'h00);
    power_cycle(1'b0);
    chk({7'h0, bus_lockout}, 8'h00);
    print_verdict();
  end
endmodule
bind rtc_core rtc_core_props #(.LOCKOUT_CYCLES(LOCKOUT_CYCLES)) i_props (.clk_sys(clk_sys), .rst_n(rst_n),
  .osc_32k(osc_32k), .sys_power_good(sys_power_good), .battery_low(battery_low),
  .master_clear_strap(master_clear_strap), .clock_reset_n(clock_reset_n), .io_sel_data(io_sel_data),
  .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .ram_bank_select(ram_bank_select),
  .ram_lock_set(ram_lock_set), .interrupt_request_n(interrupt_request_n), .bus_lockout(bus_lockout));
